// *** shared/sad_params.svh ***
`ifndef SAD_PARAMS_SVH
`define SAD_PARAMS_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define SAD_CLK_NS 25
`define SAD_DONE_PULSE_NS 400
`define SAD_DONE_CYC (`SAD_DONE_PULSE_NS / `SAD_CLK_NS)
`define SAD_START_MIN_CYC 1
`define SAD_START_MAX_CYC 8

// -----------------------------------------------------------------------------
// Search sequence
// -----------------------------------------------------------------------------
`define SAD_NBITS 10
`define SAD_BIT_CYC 8
`define SAD_CONV_CYC 80
`define SAD_CNT_W 7
`define SAD_SHOT_W 5
`define SAD_PHASE_LSB 3
`define SAD_BIT_IDX_W 4
`define SAD_MSB_CODE 10'h200
`define SAD_ZERO_CODE 10'h000

// -----------------------------------------------------------------------------
// Byte-wide result layout
// -----------------------------------------------------------------------------
`define SAD_HI_LSB 2
`define SAD_LO_PAD 6
`define SAD_BYTE_TOP 2

`endif

// *** shared/sad_pkg.sv ***
`default_nettype none

package sad_pkg;

  // Pin levels passed through the input synchronisers.
  typedef struct packed {
    logic comp_above;
    logic byte_mode;
    logic read_strobe_n;
    logic start_write_n;
    logic device_select_n;
  } sad_pins_t;

  typedef enum logic [1:0] {
    SAD_IDLE,
    SAD_HOLD,
    SAD_CONV
  } sad_state_t;

endpackage

`default_nettype wire

// *** design/sad_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sad_params.svh"

// Operation
// - While select and start are both low the search logic is held reset and no conversion runs.
// - A conversion begins 1 to 8 clocks after select or start has risen.
// - A conversion tests the MSB first, makes 10 decisions in 80 clocks, then loads the result.
// - The result is 10-bit straight binary with all ones at full scale.
// - Once the result is latched, conversion_done_n is driven low.
// - Done fed back to start with select low gives free-running conversions.
// - A start during a conversion aborts it and restarts the reset-then-convert sequence.
// - The start latch clears only on a clocked pulse after the start condition has gone.
// - Transfer fires a one-shot that holds done low for about 400 ns even during a read.
// - Select and read both low clear the done flag and enable the output latches.
// - In byte mode the result comes high byte first, left justified, low six bits zero.
// - A start request passes the synchronisers and glitch filter, so a pulse seen at fewer than two successive clock edges is lost.
module sad_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic device_select_n,
  input wire logic start_write_n,
  input wire logic read_strobe_n,
  input wire logic byte_mode,
  input wire logic comp_above,
  output logic conversion_done_n,
  output logic [`SAD_NBITS-1:0] dac_code,
  output logic [`SAD_NBITS-1:0] data_bus_lines_out,
  output logic data_bus_lines_oe,
  output logic conv_busy
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  sad_pkg::sad_pins_t pins;
  sad_pkg::sad_pins_t sync1;
  sad_pkg::sad_pins_t sync2;
  sad_pkg::sad_pins_t sync3;
  sad_pkg::sad_pins_t filt;

  assign pins = '{
    comp_above: comp_above,
    byte_mode: byte_mode,
    read_strobe_n: read_strobe_n,
    start_write_n: start_write_n,
    device_select_n: device_select_n
  };

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level is taken only when the second and third stages agree, which
  // filters a single-cycle glitch at the cost of two more clocks of latency than the second stage.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      filt <= '1;
    end else begin
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
    end
  end

  logic start_cond;
  logic rd_active;
  assign start_cond = !filt.device_select_n && !filt.start_write_n;
  assign rd_active = !filt.device_select_n && !filt.read_strobe_n;

  // ---------------------------------------------------------------------------
  // Start latch and clear gate
  // ---------------------------------------------------------------------------
  sad_pkg::sad_state_t state;
  logic start_token_flop;
  logic start_clear_gate;
  logic [`SAD_CNT_W-1:0] conv_cnt;
  logic last_cyc;

  assign start_clear_gate = start_token_flop && !start_cond;
  assign last_cyc = conv_cnt == `SAD_CNT_W'(`SAD_CONV_CYC - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= sad_pkg::SAD_IDLE;
    end else if (start_cond) begin
      state <= sad_pkg::SAD_HOLD;
    end else begin
      unique case (state)
        sad_pkg::SAD_IDLE: begin
          state <= sad_pkg::SAD_IDLE;
        end
        sad_pkg::SAD_HOLD: begin
          if (start_clear_gate) begin
            state <= sad_pkg::SAD_CONV;
          end
        end
        sad_pkg::SAD_CONV: begin
          if (last_cyc) begin
            state <= sad_pkg::SAD_IDLE;
          end
        end
      endcase
    end
  end

  // The token follows the latch by one clock, so the clear pulse can never
  // arrive in the same cycle that set the latch.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      start_token_flop <= 1'b0;
    end else begin
      start_token_flop <= state == sad_pkg::SAD_HOLD;
    end
  end

  // ---------------------------------------------------------------------------
  // Search sequencing
  // ---------------------------------------------------------------------------
  function automatic logic [`SAD_NBITS-1:0] bit_mask(
    input logic [`SAD_BIT_IDX_W-1:0] idx
  );
    bit_mask = `SAD_NBITS'(1) << idx;
  endfunction

  logic [`SAD_BIT_IDX_W-1:0] bit_step;
  logic [`SAD_BIT_IDX_W-1:0] bit_idx;
  logic decide;
  logic [`SAD_NBITS-1:0] next_trial;

  assign bit_step = conv_cnt[`SAD_CNT_W-1:`SAD_PHASE_LSB];
  assign bit_idx = `SAD_BIT_IDX_W'(`SAD_NBITS - 1) - bit_step;
  assign decide = &conv_cnt[`SAD_PHASE_LSB-1:0];

  always_comb begin
    next_trial = dac_code;
    if (!filt.comp_above) begin
      next_trial = next_trial & ~bit_mask(bit_idx);
    end
    if (bit_idx != '0) begin
      next_trial = next_trial | bit_mask(bit_idx - `SAD_BIT_IDX_W'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      conv_cnt <= '0;
    end else if (state == sad_pkg::SAD_CONV && !start_cond && !last_cyc) begin
      conv_cnt <= conv_cnt + `SAD_CNT_W'(1);
    end else begin
      conv_cnt <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dac_code <= `SAD_ZERO_CODE;
    end else if (start_cond || state == sad_pkg::SAD_HOLD && !start_clear_gate) begin
      dac_code <= `SAD_ZERO_CODE;
    end else if (state == sad_pkg::SAD_HOLD) begin
      dac_code <= `SAD_MSB_CODE;
    end else if (state == sad_pkg::SAD_CONV && decide) begin
      dac_code <= next_trial;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= state != sad_pkg::SAD_IDLE;
    end
  end

  // ---------------------------------------------------------------------------
  // Result transfer and completion flag
  // ---------------------------------------------------------------------------
  logic result_transfer_strobe;
  logic [`SAD_NBITS-1:0] result;
  logic [`SAD_SHOT_W-1:0] shot_cnt;
  logic done_set_pulse_n;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      result_transfer_strobe <= 1'b0;
    end else begin
      result_transfer_strobe <= state == sad_pkg::SAD_CONV && last_cyc && !start_cond;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      result <= `SAD_ZERO_CODE;
    end else if (state == sad_pkg::SAD_CONV && last_cyc && !start_cond) begin
      result <= next_trial;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shot_cnt <= '0;
    end else if (result_transfer_strobe) begin
      shot_cnt <= `SAD_SHOT_W'(`SAD_DONE_CYC);
    end else if (shot_cnt != '0) begin
      shot_cnt <= shot_cnt - `SAD_SHOT_W'(1);
    end
  end

  assign done_set_pulse_n = !(result_transfer_strobe || shot_cnt != '0);

  // Set wins over both clears, so a read held low across the end of a
  // conversion still shows the full completion pulse.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      conversion_done_n <= 1'b1;
    end else if (!done_set_pulse_n) begin
      conversion_done_n <= 1'b0;
    end else if (rd_active || start_cond) begin
      conversion_done_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Output latches
  // ---------------------------------------------------------------------------
  logic rd_active_q;
  logic byte_low;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rd_active_q <= 1'b0;
    end else begin
      rd_active_q <= rd_active;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      byte_low <= 1'b0;
    end else if (result_transfer_strobe) begin
      byte_low <= 1'b0;
    end else if (filt.byte_mode && rd_active_q && !rd_active) begin
      byte_low <= !byte_low;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_bus_lines_oe <= 1'b0;
    end else begin
      data_bus_lines_oe <= rd_active;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_bus_lines_out <= `SAD_ZERO_CODE;
    end else if (!rd_active) begin
      data_bus_lines_out <= `SAD_ZERO_CODE;
    end else if (!filt.byte_mode) begin
      data_bus_lines_out <= result;
    end else if (byte_low) begin
      data_bus_lines_out <= {`SAD_BYTE_TOP'(0), result[`SAD_HI_LSB-1:0],
                             `SAD_LO_PAD'(0)};
    end else begin
      data_bus_lines_out <= {`SAD_BYTE_TOP'(0), result[`SAD_NBITS-1:`SAD_HI_LSB]};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_HOLD_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_cond |=> state == sad_pkg::SAD_HOLD && conv_cnt == '0 && dac_code == '0)
    else $error("Search not held in reset under start condition.");

  AST_START_LAT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(start_cond) && state == sad_pkg::SAD_HOLD |-> ##[1:8] state == sad_pkg::SAD_CONV)
    else $error("Conversion did not begin within 8 clocks of start release.");

  AST_MSB_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(state == sad_pkg::SAD_CONV) |-> dac_code == `SAD_MSB_CODE)
    else $error("Search did not begin at the most significant bit.");

  AST_SEARCH_LEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == sad_pkg::SAD_CONV && conv_cnt == '0) ##79
    (state == sad_pkg::SAD_CONV && !start_cond &&
    conv_cnt == `SAD_CNT_W'(`SAD_CONV_CYC - 1)) |=> result_transfer_strobe)
    else $error("Transfer strobe not issued after 80 clocks.");

  AST_DONE_FALL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    result_transfer_strobe |=> !conversion_done_n ##1 !conversion_done_n)
    else $error("Done not asserted after result transfer.");

  AST_DONE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(shot_cnt == `SAD_SHOT_W'(`SAD_DONE_CYC)) |-> ##15 !conversion_done_n)
    else $error("Done pulse shorter than the one-shot time.");

  AST_READ_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_active && done_set_pulse_n |=> conversion_done_n && data_bus_lines_oe)
    else $error("Read did not clear done or enable outputs.");

  AST_OE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rd_active |=> !data_bus_lines_oe)
    else $error("Data lines driven outside a read.");

  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == sad_pkg::SAD_CONV && start_cond |=> state == sad_pkg::SAD_HOLD && !result_transfer_strobe)
    else $error("Start during conversion did not abort it.");

  AST_LATCH_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == sad_pkg::SAD_HOLD && start_cond |=> state == sad_pkg::SAD_HOLD)
    else $error("Start latch cleared while start condition persisted.");

  AST_BYTE_PAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_active && filt.byte_mode && byte_low |=> data_bus_lines_out[`SAD_LO_PAD-1:0] == '0)
    else $error("Low byte padding not zero.");

endmodule
`default_nettype wire

// *** verif/sad_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------------
// Host processor model
// ---------------------------------------------------------------------------
module sad_host_model (
  input wire logic sys_clk,
  input wire logic conversion_done_n,
  input wire logic free_run,
  output logic device_select_n,
  output logic start_write_n,
  output logic read_strobe_n
);
  logic sel_n = 1'b1;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;

  // In free-run the completion line is fed back as the start strobe, but the
  // explicit start pulse still gets through, since nothing else can kick off
  // the first conversion.
  assign device_select_n = free_run ? 1'b0 : sel_n;
  assign start_write_n = wr_n & (free_run ? conversion_done_n : 1'b1);
  assign read_strobe_n = rd_n;

  // Strobes change only just after a falling edge.
  task automatic drive(input logic sel, input logic wr, input logic rd);
    @(negedge sys_clk);
    sel_n = sel;
    wr_n = wr;
    rd_n = rd;
  endtask
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sad_params.svh"

// ---------------------------------------------------------------------------
// Stimulus and reference
// ---------------------------------------------------------------------------
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic byte_mode = 1'b0;
  logic free_run = 1'b0;
  logic [`SAD_NBITS-1:0] vin = 10'h000;
  wire logic device_select_n;
  wire logic start_write_n;
  wire logic read_strobe_n;
  wire logic comp_above;
  wire logic conversion_done_n;
  wire logic data_bus_lines_oe;
  wire logic conv_busy;
  wire logic [`SAD_NBITS-1:0] dac_code;
  wire logic [`SAD_NBITS-1:0] data_bus_lines_out;
  int n_errors = 0;
  int comparisons = 0;
  int exp_q[$];
  int vals[3];
  int k;
  int n;

  // Ideal comparator: high while the trial code is at or below the input.
  assign comp_above = (dac_code <= vin);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  sad_ctrl sad_ctrl_inst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .device_select_n(device_select_n),
    .start_write_n(start_write_n),
    .read_strobe_n(read_strobe_n),
    .byte_mode(byte_mode),
    .comp_above(comp_above),
    .conversion_done_n(conversion_done_n),
    .dac_code(dac_code),
    .data_bus_lines_out(data_bus_lines_out),
    .data_bus_lines_oe(data_bus_lines_oe),
    .conv_busy(conv_busy)
  );

  sad_host_model sad_host_model_inst (
    .sys_clk(sys_clk),
    .conversion_done_n(conversion_done_n),
    .free_run(free_run),
    .device_select_n(device_select_n),
    .start_write_n(start_write_n),
    .read_strobe_n(read_strobe_n)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    comparisons++;
    if (seen !== expd) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask

  task automatic pins(input logic sel, input logic wr, input logic rd);
    sad_host_model_inst.drive(sel, wr, rd);
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Select brackets the start pulse; the search is timed from its release.
  task automatic run_conv(input int len);
    int t1;
    int t2;
    t1 = 0;
    t2 = 0;
    pins(1'b0, 1'b0, 1'b1);
    cyc(len);
    if (len > 50) begin
      check(dac_code, 16'h0000);
      check(conv_busy, 1'b1);
      check(conversion_done_n, 1'b1);
    end
    pins(1'b0, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    exp_q.push_back(int'(vin));
    while (dac_code !== 10'h200 && t1 < 40) begin
      cyc(1);
      t1++;
    end
    check(t1 inside {[1:7]}, 1'b1);
    while (conversion_done_n !== 1'b0 && t2 < 150) begin
      cyc(1);
      t2++;
    end
    check(16'(t2), 16'h0051);
  endtask

  task automatic read_check();
    int r;
    r = exp_q.pop_front();
    // The completion pulse wins over a read, so the host waits it out first.
    cyc(16);
    pins(1'b0, 1'b1, 1'b0);
    cyc(6);
    check(data_bus_lines_oe, 1'b1);
    check(conversion_done_n, 1'b1);
    if (byte_mode)
      check(data_bus_lines_out, 16'(r / 4));
    else
      check(data_bus_lines_out, 16'(r));
    pins(1'b1, 1'b1, 1'b1);
    cyc(6);
    check(data_bus_lines_oe, 1'b0);
    if (byte_mode) begin
      pins(1'b0, 1'b1, 1'b0);
      cyc(6);
      check(data_bus_lines_out, 16'((r % 4) * 64));
      pins(1'b1, 1'b1, 1'b1);
      cyc(6);
    end
  endtask

  initial begin
    k = $urandom(42473);
    vals[0] = 'h3ff;
    vals[1] = 0;
    vals[2] = $urandom_range(1, 'h1fe);
    cyc(12);
    rst_b = 1'b1;
    cyc(2);
    check(conversion_done_n, 1'b1);
    check(data_bus_lines_oe, 1'b0);
    $display("test reset done");
    // Full scale, zero and a random code, each in both output formats.
    for (k = 0; k < 6; k++) begin
      byte_mode = k[0];
      vin = 10'(vals[k / 2]);
      run_conv((k == 1) ? 3 : ((k == 2) ? 100 : 8));
      read_check();
    end
    $display("test single conversions done");
    vin = 10'h155;
    pins(1'b0, 1'b0, 1'b1);
    cyc(6);
    pins(1'b0, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    cyc(40);
    check(conversion_done_n, 1'b1);
    check(conv_busy, 1'b1);
    run_conv(8);
    read_check();
    $display("test abort done");
    // Free-run with the outputs enabled all the time.
    byte_mode = 1'b0;
    vin = 10'(vals[2] ^ 'h2aa);
    exp_q.push_back(int'(vin));
    free_run = 1'b1;
    pins(1'b1, 1'b0, 1'b0);
    cyc(6);
    pins(1'b1, 1'b1, 1'b0);
    for (k = 0; k < 3; k++) begin
      n = 0;
      while (conversion_done_n !== 1'b0 && n < 150) begin
        cyc(1);
        n++;
      end
      check(n < 120, 1'b1);
      n = 0;
      while (conversion_done_n === 1'b0 && n < 40) begin
        cyc(1);
        n++;
      end
      check(n inside {[16:24]}, 1'b1);
      check(data_bus_lines_out, 16'(exp_q.pop_front()));
      vin = 10'($urandom_range(0, 'h3ff));
      exp_q.push_back(int'(vin));
    end
    $display("test free run done");
    conclude();
  end

  // The whole run needs about 1400 cycles; this leaves ample margin.
  initial begin
    cyc(20000);
    n_errors++;
    conclude();
  end
endmodule

`default_nettype wire
